// ---- rtl/adpp_regs.vh ----
// Register offsets, field positions, reset values and timing counts of the post-processor
`ifndef ADPP_REGS_VH
`define ADPP_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define ADPP_ADDR_CTRL 8'h00
`define ADPP_ADDR_GAIN 8'h04
`define ADPP_ADDR_WINDOW 8'h08
`define ADPP_ADDR_STATUS 8'h0C

// ==========================================================
// Control register fields
`define ADPP_CTRL_FAST_OFF 0
`define ADPP_CTRL_TRIM_EN 1
`define ADPP_CTRL_TRIM_HOLD 2
`define ADPP_CTRL_FULL_SLEEP 3
`define ADPP_CTRL_CONV_SLEEP 4
`define ADPP_CTRL_TWOS 5
`define ADPP_CTRL_WIDTH 6
`define ADPP_CTRL_RESET 6'h00

// ==========================================================
// Gain and window fields
`define ADPP_GAIN_WIDTH 4
`define ADPP_GAIN_RESET 4'h0
`define ADPP_GAIN_MAX 4'hC
`define ADPP_WIN_WIDTH 4
`define ADPP_WIN_RESET 4'h0
`define ADPP_WIN_MAX 4'hB

// ==========================================================
// Status register fields
`define ADPP_STAT_FAST 0
`define ADPP_STAT_VALID 1
`define ADPP_STAT_CORE_PD 2
`define ADPP_STAT_WIN_LSB 4
`define ADPP_STAT_EST_LSB 16

// ==========================================================
// Datapath constants
`define ADPP_FAST_LATENCY 10
`define ADPP_PROC_EXTRA 3
`define ADPP_COEF_FRAC 12
`define ADPP_TRIM_LIMIT 8'h52
`define ADPP_BASE_SHIFT 20

// ==========================================================
// Timing
`define ADPP_CLK_NS 20
`define ADPP_FULL_WAKE_NS 100000
`define ADPP_CONVERTER_SLEEP_WAKE_NS 5000
`define ADPP_FULL_WAKE_CYC ((`ADPP_FULL_WAKE_NS + `ADPP_CLK_NS - 1) / `ADPP_CLK_NS)
`define ADPP_CONVERTER_SLEEP_WAKE_CYC ((`ADPP_CONVERTER_SLEEP_WAKE_NS + `ADPP_CLK_NS - 1) / `ADPP_CLK_NS)

`endif

// ---- rtl/adpp_postproc.v ----
// Converter post-processing: fast path, gain, dc trim loop, sleep control and register port
`timescale 1ns/1ps
`include "adpp_regs.vh"

module adpp_postproc #(
  parameter W = 14,
  parameter BASE_SHIFT = `ADPP_BASE_SHIFT,
  parameter FULL_WAKE_CYC = `ADPP_FULL_WAKE_CYC,
  parameter CONVERTER_SLEEP_WAKE_CYC = `ADPP_CONVERTER_SLEEP_WAKE_CYC
) (
  input wire I_CLK,
  input wire I_RESET,
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [W-1:0] I_SAMPLE,
  output reg [31:0] O_RDATA,
  output reg [W-1:0] O_DATA,
  output reg O_DATA_OE,
  output reg O_DATA_VALID,
  output reg O_CORE_PD,
  output reg O_REF_PD
);

  localparam ACC_W = W + BASE_SHIFT + 12;
  localparam WAKE_W = 16;
  localparam [W-1:0] POS_FS = {1'b0, {(W-1){1'b1}}};
  localparam [W-1:0] NEG_FS = {1'b1, {(W-1){1'b0}}};
  localparam LAT_FAST = `ADPP_FAST_LATENCY;

  // ==========================================================
  // Gain coefficient table, 0.5 dB per code, Q.12
  function [14:0] gain_coef;
    input [3:0] code;
    begin
      case (code)
        4'h0: gain_coef = 15'h1000;
        4'h1: gain_coef = 15'h10F3;
        4'h2: gain_coef = 15'h11F4;
        4'h3: gain_coef = 15'h1304;
        4'h4: gain_coef = 15'h1425;
        4'h5: gain_coef = 15'h1556;
        4'h6: gain_coef = 15'h169A;
        4'h7: gain_coef = 15'h17F1;
        4'h8: gain_coef = 15'h195C;
        4'h9: gain_coef = 15'h1ADC;
        4'hA: gain_coef = 15'h1C74;
        4'hB: gain_coef = 15'h1E23;
        default: gain_coef = 15'h2000;
      endcase
    end
  endfunction

  // ==========================================================
  // Offset binary and signed codes differ only in the top bit
  function [W-1:0] flip_msb;
    input [W-1:0] code;
    begin
      flip_msb = {~code[W-1], code[W-2:0]};
    end
  endfunction

  // ==========================================================
  // Legal window codes; reserved ones must never reach the loop
  function win_legal;
    input [3:0] code;
    begin
      if (code <= `ADPP_WIN_MAX) begin
        win_legal = 1'b1;
      end else begin
        win_legal = 1'b0;
      end
    end
  endfunction

  // ==========================================================
  // Registers
  reg [`ADPP_CTRL_WIDTH-1:0] ctrl_reg;
  reg [`ADPP_GAIN_WIDTH-1:0] gain_reg;
  reg [`ADPP_WIN_WIDTH-1:0] win_reg;
  wire fast_path = ~ctrl_reg[`ADPP_CTRL_FAST_OFF];
  wire trim_on = ctrl_reg[`ADPP_CTRL_TRIM_EN] & ~fast_path;
  wire trim_hold = ctrl_reg[`ADPP_CTRL_TRIM_HOLD];
  wire full_sleep = ctrl_reg[`ADPP_CTRL_FULL_SLEEP];
  wire conv_sleep = ctrl_reg[`ADPP_CTRL_CONV_SLEEP];
  wire twos = ctrl_reg[`ADPP_CTRL_TWOS];

  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl_reg <= `ADPP_CTRL_RESET;
      gain_reg <= `ADPP_GAIN_RESET;
      win_reg <= `ADPP_WIN_RESET;
    end else if (I_WR) begin
      case (I_ADDR)
        `ADPP_ADDR_CTRL: begin
          ctrl_reg <= I_WDATA[`ADPP_CTRL_WIDTH-1:0];
        end
        `ADPP_ADDR_GAIN: begin
          gain_reg <= I_WDATA[`ADPP_GAIN_WIDTH-1:0];
        end
        `ADPP_ADDR_WINDOW: begin
          // Reserved codes are dropped so the loop never runs undefined
          if (win_legal(I_WDATA[`ADPP_WIN_WIDTH-1:0])) begin
            win_reg <= I_WDATA[`ADPP_WIN_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Raw delay line, nine stages ahead of the output register
  reg [W-1:0] dly_reg [0:LAT_FAST-2];
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      dly_reg[0] <= {W{1'b0}};
    end else begin
      dly_reg[0] <= I_SAMPLE;
    end
  end
  genvar gi;
  generate
    for (gi = 1; gi < LAT_FAST - 1; gi = gi + 1) begin : g_dly
      always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
          dly_reg[gi] <= {W{1'b0}};
        end else begin
          dly_reg[gi] <= dly_reg[gi-1];
        end
      end
    end
  endgenerate
  wire [W-1:0] raw = dly_reg[LAT_FAST-2];
  wire signed [W-1:0] raw_s = flip_msb(raw);

  // ==========================================================
  // Dc trim loop: leaky integrator, time constant 2^(BASE_SHIFT+window)
  // Limitation: the estimate needs several time constants to settle, so
  // holding too early freezes a partly built estimate
  reg signed [ACC_W-1:0] acc_reg;
  reg signed [W-1:0] est_reg;
  wire [5:0] shift = BASE_SHIFT[5:0] + {2'b00, win_reg};
  wire signed [ACC_W-1:0] acc_est = acc_reg >>> shift;
  wire signed [ACC_W-1:0] acc_next = acc_reg + {{(ACC_W-W){raw_s[W-1]}}, raw_s} - acc_est;
  wire signed [ACC_W-1:0] lim_p = {{(ACC_W-8){1'b0}}, `ADPP_TRIM_LIMIT};
  wire signed [ACC_W-1:0] lim_n = -lim_p;
  reg signed [W-1:0] est_next;
  always @* begin
    if (acc_est > lim_p) begin
      est_next = lim_p[W-1:0];
    end else if (acc_est < lim_n) begin
      est_next = lim_n[W-1:0];
    end else begin
      est_next = acc_est[W-1:0];
    end
  end

  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      acc_reg <= {ACC_W{1'b0}};
      est_reg <= {W{1'b0}};
    end else if (!trim_on) begin
      acc_reg <= {ACC_W{1'b0}};
      est_reg <= {W{1'b0}};
    end else if (!trim_hold) begin
      acc_reg <= acc_next;
      est_reg <= est_next;
    end
    // Holding keeps est_reg, still subtracted below
  end

  // ==========================================================
  // Processing pipeline: subtract, scale, saturate
  reg signed [W:0] p1_reg;
  reg signed [W+3:0] p2_reg;
  reg [W-1:0] p3_reg;
  wire signed [W:0] diff = {raw_s[W-1], raw_s} - {est_reg[W-1], est_reg};
  wire signed [W+15:0] prod = p1_reg * $signed({1'b0, gain_coef(gain_reg)});
  wire signed [W+15:0] scaled = prod >>> `ADPP_COEF_FRAC;
  wire signed [W+3:0] pos_lim = {{4{1'b0}}, POS_FS};
  wire signed [W+3:0] neg_lim = {{4{1'b1}}, NEG_FS};
  reg [W-1:0] sat;
  always @* begin
    if (p2_reg > pos_lim) begin
      sat = POS_FS;
    end else if (p2_reg < neg_lim) begin
      sat = NEG_FS;
    end else begin
      sat = p2_reg[W-1:0];
    end
  end

  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      p1_reg <= {(W+1){1'b0}};
      p2_reg <= {(W+4){1'b0}};
      p3_reg <= {W{1'b0}};
    end else begin
      p1_reg <= trim_on ? diff : {raw_s[W-1], raw_s};
      p2_reg <= scaled[W+3:0];
      p3_reg <= sat;
    end
  end

  // ==========================================================
  // Sleep control and wake-up counter
  reg [WAKE_W-1:0] wake_cnt_reg;
  reg full_prev_reg;
  reg conv_prev_reg;
  wire full_rel = full_prev_reg & ~full_sleep;
  wire conv_rel = conv_prev_reg & ~conv_sleep;
  // Previous sleep bits mark the cycle in which a sleep is released
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      full_prev_reg <= 1'b0;
      conv_prev_reg <= 1'b0;
    end else begin
      full_prev_reg <= full_sleep;
      conv_prev_reg <= conv_sleep;
    end
  end

  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      wake_cnt_reg <= {WAKE_W{1'b0}};
    end else begin
      if (full_sleep || conv_sleep) begin
        wake_cnt_reg <= {WAKE_W{1'b0}};
      end else if (full_rel) begin
        wake_cnt_reg <= FULL_WAKE_CYC[WAKE_W-1:0];
      end else if (conv_rel) begin
        wake_cnt_reg <= CONVERTER_SLEEP_WAKE_CYC[WAKE_W-1:0];
      end else if (wake_cnt_reg != {WAKE_W{1'b0}}) begin
        wake_cnt_reg <= wake_cnt_reg - 1'b1;
      end
    end
  end
  wire awake = ~full_sleep & ~conv_sleep & ~full_rel & ~conv_rel &
               (wake_cnt_reg == {WAKE_W{1'b0}});

  // ==========================================================
  // Output registers
  wire [W-1:0] sel = fast_path ? flip_msb(raw) : p3_reg;
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_DATA <= {W{1'b0}};
    end else begin
      // Format applies on both paths; sel is held signed here
      O_DATA <= twos ? sel : flip_msb(sel);
    end
  end

  // ==========================================================
  // Power and valid flags
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_DATA_OE <= 1'b0;
      O_DATA_VALID <= 1'b0;
      O_CORE_PD <= 1'b0;
      O_REF_PD <= 1'b0;
    end else begin
      O_DATA_OE <= ~full_sleep;
      O_DATA_VALID <= awake;
      O_CORE_PD <= full_sleep | conv_sleep;
      O_REF_PD <= full_sleep;
    end
  end

  // ==========================================================
  // Status word, assembled apart from the read mux
  reg [31:0] status_word;
  always @* begin
    status_word = 32'h00000000;
    status_word[`ADPP_STAT_FAST] = fast_path;
    status_word[`ADPP_STAT_VALID] = O_DATA_VALID;
    status_word[`ADPP_STAT_CORE_PD] = O_CORE_PD;
    status_word[`ADPP_STAT_WIN_LSB +: `ADPP_WIN_WIDTH] = win_reg;
    status_word[`ADPP_STAT_EST_LSB +: 16] = {{(16-W){est_reg[W-1]}}, est_reg};
  end

  // ==========================================================
  // Register read port, data one cycle after the strobe
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_RDATA <= 32'h00000000;
    end else if (I_RD) begin
      case (I_ADDR)
        `ADPP_ADDR_CTRL: begin
          O_RDATA <= {{(32-`ADPP_CTRL_WIDTH){1'b0}}, ctrl_reg};
        end
        `ADPP_ADDR_GAIN: begin
          O_RDATA <= {{(32-`ADPP_GAIN_WIDTH){1'b0}}, gain_reg};
        end
        `ADPP_ADDR_WINDOW: begin
          O_RDATA <= {{(32-`ADPP_WIN_WIDTH){1'b0}}, win_reg};
        end
        `ADPP_ADDR_STATUS: begin
          O_RDATA <= status_word;
        end
        default: begin
          O_RDATA <= 32'h00000000;
        end
      endcase
    end else begin
      O_RDATA <= 32'h00000000;
    end
  end

endmodule

// ---- testbench/adpp_postproc_checker.sv ----
// Port-level assertions for the converter post-processor
`timescale 1ns/1ps
`include "adpp_regs.vh"
module adpp_postproc_checker #(
  parameter W = 14
) (
  input wire I_CLK,
  input wire I_RESET,
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [W-1:0] I_SAMPLE,
  input wire [31:0] O_RDATA,
  input wire [W-1:0] O_DATA,
  input wire O_DATA_OE,
  input wire O_DATA_VALID,
  input wire O_CORE_PD,
  input wire O_REF_PD
);
  // ==========================================================
  // Shadow of the control bits
  reg [5:0] ctrl_reg;
  reg [3:0] quiet_reg;
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl_reg <= 6'h00;
      quiet_reg <= 4'h0;
    end else if (I_WR && I_ADDR == `ADPP_ADDR_CTRL) begin
      ctrl_reg <= I_WDATA[5:0];
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hF) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking dcb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  // ==========================================================
  // Assertions
  // Settle time after a mode change keeps old samples out of the comparison
  AST_FAST_LATENCY: assert property (quiet_reg == 4'hF && ctrl_reg == 6'h00 && O_DATA_VALID
    |-> O_DATA == $past(I_SAMPLE, 10)) else $error("fast path sample mismatch");
  AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data not idle");
  AST_RD_CTRL: assert property (I_RD && I_ADDR == `ADPP_ADDR_CTRL
    |=> O_RDATA == {26'h0, ctrl_reg}) else $error("control readback wrong");
  AST_FULL_SLEEP: assert property (ctrl_reg[3]
    |=> !O_DATA_OE && O_CORE_PD && O_REF_PD) else $error("full sleep outputs wrong");
  AST_STANDBY: assert property (ctrl_reg[4] && !ctrl_reg[3]
    |=> O_CORE_PD && !O_REF_PD && O_DATA_OE && !O_DATA_VALID) else $error("standby wrong");
  AST_AWAKE: assert property (ctrl_reg[4:3] == 2'h0
    |=> !O_CORE_PD && !O_REF_PD && O_DATA_OE) else $error("awake outputs wrong");
  AST_FULL_WAKE_HOLD: assert property ($fell(ctrl_reg[3]) |-> !O_DATA_VALID [*8])
    else $error("data valid too early");
  AST_FULL_WAKE_END: assert property ($fell(ctrl_reg[3]) && !ctrl_reg[4]
    |-> ##[18:40] O_DATA_VALID) else $error("full wake window wrong");
  AST_CONVERTER_SLEEP_WAKE: assert property ($fell(ctrl_reg[4]) && !ctrl_reg[3]
    |-> !O_DATA_VALID ##[6:30] O_DATA_VALID) else $error("standby wake wrong");
  cover property ($fell(ctrl_reg[3]));
  cover property ($fell(ctrl_reg[4]));
  cover property (ctrl_reg[1:0] == 2'h3);
endmodule
bind adpp_postproc adpp_postproc_checker #(.W(W)) chk (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_SAMPLE(I_SAMPLE),
  .O_RDATA(O_RDATA), .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE), .O_DATA_VALID(O_DATA_VALID),
  .O_CORE_PD(O_CORE_PD), .O_REF_PD(O_REF_PD));

// ---- testbench/adpp_sample_src.sv ----
// Converter core stand-in: a held code or a free-running ramp
`timescale 1ns/1ps
module adpp_sample_src (
  input wire i_clk,
  input wire i_reset,
  input wire i_ramp,
  input wire [13:0] i_code,
  output wire [13:0] o_sample
);
  reg [13:0] ramp_reg;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ramp_reg <= 14'h0000;
    end else begin
      ramp_reg <= ramp_reg + 14'h0001;
    end
  end
  // A ramp gives every cycle its own code, so a latency slip cannot hide
  assign o_sample = i_ramp ? ramp_reg : i_code;
endmodule

// ---- testbench/adpp_postproc_test.sv ----
// Self-checking bench for the converter post-processor
`timescale 1ns/1ps
module adpp_postproc_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg ramp = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [13:0] code = 14'h1234;
  wire [13:0] smp;
  wire [13:0] dout;
  wire [31:0] rdata;
  wire oe;
  wire vld;
  wire cpd;
  wire rpd;
  integer n_fail = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer k;
  adpp_sample_src src (.i_clk(clk), .i_reset(rst), .i_ramp(ramp), .i_code(code),
    .o_sample(smp));
  // Short wake and loop counts keep the run brief
  adpp_postproc #(.BASE_SHIFT(4), .FULL_WAKE_CYC(20), .CONVERTER_SLEEP_WAKE_CYC(8)) dut (
    .I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_SAMPLE(smp), .O_RDATA(rdata), .O_DATA(dout), .O_DATA_OE(oe), .O_DATA_VALID(vld),
    .O_CORE_PD(cpd), .O_REF_PD(rpd));
  initial begin
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Read data is taken at the edge that closes its one-cycle slot
  task rd_reg(input [7:0] a, input [31:0] exp);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      chk("rdata", exp, rdata);
    end
  endtask
  task step(input [13:0] nc, input integer lat, input [13:0] e_old, input [13:0] e_new);
    begin
      code <= nc;
      repeat (lat) @(posedge clk);
      chk("dout old", 32'(e_old), 32'(dout));
      @(posedge clk);
      chk("dout new", 32'(e_new), 32'(dout));
    end
  endtask
  task wake(input integer lo, input integer hi);
    begin
      k = 0;
      while (vld !== 1'b1 && k < 100) begin
        @(posedge clk);
        k = k + 1;
      end
      chk("wake", 32'h1, 32'(k >= lo && k < hi));
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(8'h00, 32'h0);
    rd_reg(8'h04, 32'h0);
    rd_reg(8'h08, 32'h0);
    rd_reg(8'h0C, 32'h3);
    rd_reg(8'h10, 32'h0);
    ramp <= 1'b0;
    $display("Test reset done");
    wr_reg(8'h00, 32'h6);
    step(14'h2100, 10, 14'h1234, 14'h2100);
    wr_reg(8'h00, 32'h1);
    step(14'h2040, 13, 14'h2100, 14'h2040);
    wr_reg(8'h04, 32'hC);
    step(14'h2100, 13, 14'h2080, 14'h2200);
    step(14'h3100, 13, 14'h2200, 14'h3FFF);
    step(14'h0000, 13, 14'h3FFF, 14'h0000);
    wr_reg(8'h00, 32'h21);
    step(14'h3100, 13, 14'h2000, 14'h1FFF);
    $display("Test gain done");
    wr_reg(8'h04, 32'h0);
    code <= 14'h2020;
    wr_reg(8'h00, 32'h3);
    repeat (300) @(posedge clk);
    chk("trim", 32'h2000, 32'(dout));
    rd_reg(8'h0C, 32'h00200002);
    wr_reg(8'h00, 32'h7);
    code <= 14'h2100;
    repeat (30) @(posedge clk);
    chk("hold", 32'h20E0, 32'(dout));
    wr_reg(8'h00, 32'h3);
    repeat (300) @(posedge clk);
    chk("clamp", 32'h20AE, 32'(dout));
    for (k = 0; k < 12; k = k + 1) begin
      wr_reg(8'h08, k);
      rd_reg(8'h08, k);
    end
    wr_reg(8'h08, 32'hC);
    rd_reg(8'h08, 32'hB);
    wr_reg(8'h00, 32'h1);
    rd_reg(8'h0C, 32'hB2);
    $display("Test trim done");
    wr_reg(8'h00, 32'h8);
    repeat (2) @(posedge clk);
    chk("sleep", 32'h3, {29'h0, oe, rpd, cpd});
    wr_reg(8'h00, 32'h0);
    wake(18, 40);
    wr_reg(8'h00, 32'h10);
    repeat (2) @(posedge clk);
    chk("standby", 32'h5, {29'h0, oe, rpd, cpd});
    wr_reg(8'h00, 32'h0);
    wake(6, 18);
    wr_reg(8'h10, 32'h3F);
    rd_reg(8'h00, 32'h0);
    $display("Test sleep done");
    finish_test;
  end
endmodule
